// >>> logic/rms_pkg.sv
package rms_pkg;

  // ***********************************************************
  // Operating modes
  // ***********************************************************
  typedef enum logic [1:0] {
    RMS_RUN,
    RMS_STOP,
    RMS_LOWPOWER_STOP_MODE,
    RMS_STANDBY
  } rms_mode_e;

  // ***********************************************************
  // Carriers
  // ***********************************************************
  typedef struct packed {
    logic       reset_pulse_control;  // Enables programmable width
    logic [4:0] min_reset_duration;   // Width in milliseconds
  } rms_dur_cfg_s;

  typedef struct packed {
    logic out;   // Level driven onto the pad
    logic oe_n;  // Low while the pad is driven
  } rms_pad_s;

  // ***********************************************************
  // Constants
  // ***********************************************************
  localparam int          RMS_DUR_W        = 5;
  localparam int          RMS_CLK_HZ       = 10_000_000;
  localparam int          RMS_UNIT_MS      = 1;
  localparam int          RMS_CYC_PER_UNIT = RMS_CLK_HZ / 1000 * RMS_UNIT_MS;
  localparam logic [4:0]  RMS_DUR_DEFAULT  = 5'h01;
  localparam int          RMS_HOLDOFF      = 3;
  localparam rms_mode_e   RMS_MODE_RST     = RMS_STANDBY;
  localparam logic        RMS_SUPPLY_RST   = 1'h0;
  localparam logic        RMS_LP_N_RST     = 1'h0;
  localparam logic        RMS_OE_N_RST     = 1'h1;
  localparam logic        RMS_PAD_OUT_VAL  = 1'h0;

endpackage

// >>> logic/rms_pulse_timer.sv
`timescale 1ns/10ps
module rms_pulse_timer
  import rms_pkg::*;
#(
  parameter int CYC_PER_UNIT = RMS_CYC_PER_UNIT,
  parameter int UNIT_W       = RMS_DUR_W
) (
  input  wire logic              sys_clk,  // System clock
  input  wire logic              rst_n,    // Synchronous reset, active low
  input  wire logic              start,    // Load request, ignored when busy
  input  wire logic [UNIT_W-1:0] units,    // Pulse length in units, not 0
  output logic                   busy      // High for units*CYC_PER_UNIT
);

  localparam int PRE_W = (CYC_PER_UNIT > 1) ? $clog2(CYC_PER_UNIT) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_UNIT - 1);

  logic [UNIT_W-1:0] units_q;
  logic [PRE_W-1:0]  pre_q;

  assign busy = (units_q != '0);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      units_q <= '0;
      pre_q   <= '0;
    end else if (!busy) begin
      units_q <= start ? units : '0;
      pre_q   <= '0;
    end else if (pre_q == PRE_LAST) begin
      units_q <= units_q - UNIT_W'(1);
      pre_q   <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

endmodule

// >>> logic/rms_regulator_signals.sv
`timescale 1ns/10ps
module rms_regulator_signals
  import rms_pkg::*;
#(
  parameter int CYC_PER_UNIT = RMS_CYC_PER_UNIT
) (
  input  wire logic         sys_clk,             // 10 MHz clock
  input  wire logic         rst_n,               // Sync reset, active low
  input  rms_mode_e         mode,                // Current operating mode
  input  wire logic         watchdog1_reset_out, // First watchdog reset
  input  wire logic         watchdog2_reset_out, // Second watchdog reset
  input  rms_dur_cfg_s      dur_cfg,             // Pulse width control
  input  wire logic         bidir_reset_n_in,    // Pad level, async
  output logic              bidir_reset_n_out,   // Pad drive level
  output logic              bidir_reset_n_oe_n,  // Low while pad driven
  output logic              supply_request_out,  // Active high
  output logic              lowpower_request_n,  // Active low
  output logic              reset_sensed         // External reset seen
);

  // ***********************************************************
  // Mode register and crash pulse timer
  // ***********************************************************
  rms_mode_e            mode_q;
  logic                 crash_req;
  logic                 busy;
  logic [RMS_DUR_W-1:0] units_eff;
  rms_pad_s             pad_q;
  logic                 supply_q;
  logic                 lp_n_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_q <= RMS_MODE_RST;
    end else begin
      mode_q <= mode;
    end
  end

  assign crash_req = watchdog1_reset_out | watchdog2_reset_out;

  // Disabled or zero width falls back to one unit so a pulse is visible
  assign units_eff = (dur_cfg.reset_pulse_control &&
                      dur_cfg.min_reset_duration != '0) ?
                     dur_cfg.min_reset_duration : RMS_DUR_DEFAULT;

  rms_pulse_timer #(
    .CYC_PER_UNIT (CYC_PER_UNIT),
    .UNIT_W       (RMS_DUR_W)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (crash_req),
    .units   (units_eff),
    .busy    (busy)
  );

  // ***********************************************************
  // Regulator request outputs
  // ***********************************************************
  // Crash pulse overrides mode so peripherals cycle via pad only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      supply_q <= RMS_SUPPLY_RST;
    end else begin
      supply_q <= busy || (mode_q != RMS_STANDBY);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lp_n_q <= RMS_LP_N_RST;
    end else begin
      lp_n_q <= busy || mode_q inside {RMS_RUN, RMS_STOP};
    end
  end

  assign supply_request_out = supply_q;
  assign lowpower_request_n = lp_n_q;

  // ***********************************************************
  // Reset pad drive and sense
  // ***********************************************************
  logic                   pad_s1_q;
  logic                   pad_s2_q;
  logic [RMS_HOLDOFF-1:0] drv_hist_q;
  logic                   sensed_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pad_q.out  <= RMS_PAD_OUT_VAL;
      pad_q.oe_n <= RMS_OE_N_RST;
    end else begin
      pad_q.out  <= RMS_PAD_OUT_VAL;
      pad_q.oe_n <= !busy;
    end
  end

  assign bidir_reset_n_out  = pad_q.out;
  assign bidir_reset_n_oe_n = pad_q.oe_n;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pad_s1_q <= 1'h1;
      pad_s2_q <= 1'h1;
    end else begin
      pad_s1_q <= bidir_reset_n_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  // Own drive echoes back through the synchroniser; mask it meanwhile
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drv_hist_q <= '0;
    end else begin
      drv_hist_q <= {drv_hist_q[RMS_HOLDOFF-2:0], !pad_q.oe_n};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sensed_q <= 1'h0;
    end else begin
      sensed_q <= !pad_s2_q && pad_q.oe_n && (drv_hist_q == '0);
    end
  end

  assign reset_sensed = sensed_q;

  // ***********************************************************
  // Checks
  // ***********************************************************
  logic [31:0] drive_len_q;
  logic [31:0] exp_len_q;
  logic [31:0] exp_cur_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_len_q <= '0;
    end else begin
      drive_len_q <= pad_q.oe_n ? 32'h0 : drive_len_q + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      exp_len_q <= '0;
    end else if (crash_req && !busy) begin
      exp_len_q <= 32'(units_eff) * 32'(CYC_PER_UNIT);
    end
  end

  // Latched as drive starts; a held watchdog reloads exp_len_q early
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      exp_cur_q <= '0;
    end else if (busy && pad_q.oe_n) begin
      exp_cur_q <= exp_len_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_SUPPLY_OFF: assert property (
    mode_q == RMS_STANDBY && !busy |=> !supply_request_out)
    else $error("supply request high in standby");

  AST_SUPPLY_ON: assert property (
    mode_q != RMS_STANDBY |=> supply_request_out)
    else $error("supply request low outside standby");

  AST_LP_ACTIVE: assert property (
    mode_q inside {RMS_LOWPOWER_STOP_MODE, RMS_STANDBY} && !busy
    |=> !lowpower_request_n)
    else $error("low-power request not asserted");

  AST_LP_IDLE: assert property (
    mode_q inside {RMS_RUN, RMS_STOP} |=> lowpower_request_n)
    else $error("low-power request asserted in run or stop");

  AST_CRASH_LEVELS: assert property (
    !bidir_reset_n_oe_n |-> supply_request_out && lowpower_request_n)
    else $error("requests not held during crash pulse");

  AST_CRASH_START: assert property (
    crash_req && bidir_reset_n_oe_n && !busy |-> ##2 !bidir_reset_n_oe_n)
    else $error("crash pulse did not start two cycles after watchdog");

  AST_PULSE_LEN: assert property (
    $rose(bidir_reset_n_oe_n) |-> drive_len_q == exp_cur_q)
    else $error("reset pulse width differs from programmed duration");

  AST_PAD_LOW: assert property (
    !bidir_reset_n_out && bidir_reset_n_oe_n == !$past(busy))
    else $error("reset pad not driven low while timer busy");

  AST_SENSE: assert property (
    !pad_s2_q && bidir_reset_n_oe_n && drv_hist_q == '0
    |=> reset_sensed)
    else $error("external reset not sensed");

  AST_GLITCH_FREE: assert property (
    $stable(mode_q) && $stable(busy)
    |=> $stable(supply_request_out) && $stable(lowpower_request_n))
    else $error("request output changed without cause");

  COV_STANDBY: cover property (
    mode_q == RMS_STANDBY ##1 !supply_request_out);

  COV_CRASH: cover property (
    $fell(bidir_reset_n_oe_n) ##1 supply_request_out);

  COV_EXT_RESET: cover property ($rose(reset_sensed));

  COV_RETRIGGER: cover property (
    $rose(bidir_reset_n_oe_n) ##1 !bidir_reset_n_oe_n);

endmodule

// >>> tb/rms_far_side.sv
`timescale 1ns/10ps
module rms_far_side (
  input  wire logic supply_request_out,  // Supply request from device
  input  wire logic pad_out,             // Device pad drive level
  input  wire logic pad_oe_n,            // Low while device drives pad
  input  wire logic ext_reset_low,       // Outside reset source
  output logic      pad_level,           // Resolved pad level
  output logic      gated_supply_enable, // Peripheral regulator enable
  output logic      usb_hs_phy_supply    // USB PHY rail enable
);
  // Discrete parts: pin stays a plain mode request
  localparam logic SUPPLY_PIN_CONFIG = 1'b0;
  // Pull-up wins once every driver lets go
  assign pad_level = ~((~pad_oe_n & ~pad_out) | ext_reset_low);
  assign gated_supply_enable = supply_request_out & pad_level
                               & ~SUPPLY_PIN_CONFIG;
  // Never ahead of the internal rail
  assign usb_hs_phy_supply = gated_supply_enable;
endmodule

// >>> tb/regulator_mode_signalling_tb.sv
`timescale 1ns/10ps
module regulator_mode_signalling_tb;
  import rms_pkg::*;
  localparam int CPU = 10;
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  rms_mode_e    mode = RMS_RUN;
  logic         wd1 = 1'b0;
  logic         wd2 = 1'b0;
  logic         ext_low = 1'b0;
  rms_dur_cfg_s dur_cfg = '0;
  logic         pad, pad_out, pad_oe_n, supply, lp_n, sensed, gated, usb;
  int           num_errors = 0;
  int           checked = 0;
  int           cycles = 0;
  int           len;

  rms_regulator_signals #(.CYC_PER_UNIT(CPU)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .mode(mode),
    .watchdog1_reset_out(wd1), .watchdog2_reset_out(wd2),
    .dur_cfg(dur_cfg), .bidir_reset_n_in(pad),
    .bidir_reset_n_out(pad_out), .bidir_reset_n_oe_n(pad_oe_n),
    .supply_request_out(supply), .lowpower_request_n(lp_n),
    .reset_sensed(sensed));
  rms_far_side far (
    .supply_request_out(supply), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .ext_reset_low(ext_low), .pad_level(pad),
    .gated_supply_enable(gated), .usb_hs_phy_supply(usb));

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("Errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ***********************************************************
  // Reference model
  // ***********************************************************
  function automatic logic m_sup(rms_mode_e m);
    return m != RMS_STANDBY;
  endfunction
  function automatic logic m_lpn(rms_mode_e m);
    return m == RMS_RUN || m == RMS_STOP;
  endfunction

  task set_mode(input rms_mode_e m);
    logic old;
    old = m_sup(mode);
    @(negedge sys_clk) mode = m;
    @(negedge sys_clk);
    check(supply, old);
    repeat (2) @(negedge sys_clk);
    check(supply, m_sup(m));
    check(lp_n, m_lpn(m));
    check(gated, m_sup(m));
    check(usb, m_sup(m));
  endtask

  task crash(input bit which, input logic ctl, input logic [4:0] n,
             input rms_mode_e m);
    int lim;
    int w;
    set_mode(m);
    dur_cfg = '{ctl, n};
    if (which) wd2 = 1'b1;
    else wd1 = 1'b1;
    @(negedge sys_clk);
    wd1 = 1'b0;
    wd2 = 1'b0;
    lim = 0;
    while (pad_oe_n !== 1'b0 && lim < 10) begin
      @(negedge sys_clk);
      lim++;
    end
    check(lim, 1);
    w = 0;
    while (pad_oe_n === 1'b0 && w < 400) begin
      check({supply, lp_n, gated, pad, usb}, 5'h18);
      @(negedge sys_clk);
      w++;
    end
    check(w, ((ctl && n != 5'h00) ? int'(n) : 1) * CPU);
    repeat (2) @(negedge sys_clk);
    check({supply, lp_n}, {m_sup(m), m_lpn(m)});
    check(sensed, 1'h0);
    repeat (4) @(negedge sys_clk);
  endtask

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    void'($urandom(88485));
    repeat (20) @(negedge sys_clk);
    check({supply, lp_n, pad_oe_n}, 3'h1);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) set_mode(rms_mode_e'(i));
    repeat (8) set_mode(rms_mode_e'($urandom_range(3)));
    crash(1'b0, 1'b1, 5'h1f, RMS_STANDBY);
    crash(1'b1, 1'b0, 5'h07, RMS_RUN);
    crash(1'b0, 1'b1, 5'h00, RMS_LOWPOWER_STOP_MODE);
    crash(1'b1, 1'b1, 5'h01, RMS_STOP);
    repeat (3) crash(1'($urandom_range(1)), 1'b1, 5'($urandom_range(31)),
                     rms_mode_e'($urandom_range(3)));
    // Held watchdog restarts the pulse after one released cycle
    dur_cfg = '{1'h1, 5'h02};
    wd1 = 1'h1;
    repeat (2 * CPU + 1) @(negedge sys_clk);
    dur_cfg = '{1'h1, 5'h03};
    @(negedge sys_clk);
    check(pad_oe_n, 1'h1);
    @(negedge sys_clk) wd1 = 1'h0;
    check({pad_oe_n, supply, lp_n}, 3'h3);
    len = 0;
    while (pad_oe_n === 1'h0 && len < 400) begin
      @(negedge sys_clk);
      len++;
    end
    check(len, 3 * CPU);
    repeat (4) @(negedge sys_clk);
    // External reset is sensed, not echoed as own drive
    @(negedge sys_clk) ext_low = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(sensed, 1'b0);
    @(negedge sys_clk);
    check({sensed, pad_oe_n, gated}, 3'h6);
    @(negedge sys_clk) ext_low = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({sensed, gated}, {1'b0, m_sup(mode)});
    rst_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    check({supply, lp_n}, 2'h0);
    end_sim();
  end
endmodule
